/* bench/count_pulse_source.sv */
// Model of an external pulse source on one count pin.
// Assumes hclk is the sampling clock; edges land well away from its rising edge.
module count_pulse_source (
    input wire logic hclk,
    input wire logic run,
    input wire logic [3:0] half,
    output logic pin
);
    timeunit 1ns;
    timeprecision 100ps;
    int n = 0;
    initial pin = 1'b0;
    // The pin stays put while stopped, so mode switches can be made on a steady pin.
    always @(posedge hclk) begin
        n = run ? n + 1 : 0;
        if (n >= half) begin
            n = 0;
            #17 pin = ~pin;
        end
    end
endmodule

/* bench/tb_timer_prescaler_ext_clock_sync.sv */
// Self-checking bench for the tick prescaler and count pin front end.
// Assumes the pulse source model and the checker are compiled before it.
module tb_timer_prescaler_ext_clock_sync
    import tick_gen_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, run = 2'h0, timer_tick;
    logic [3:0] half = 4'h2;
    wire logic hready;
    wire logic [1:0] pin;
    int mismatches = 0, n_compared = 0, st, nt, ne;
    int ft[2];
    timer_prescaler_ext_clock_sync dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .ext_count_pin(pin), .timer_tick(timer_tick));
    count_pulse_source src0 (.hclk(hclk), .run(run[0]), .half(half), .pin(pin[0]));
    count_pulse_source src1 (.hclk(hclk), .run(run[1]), .half(half), .pin(pin[1]));
    initial begin
        forever #25 hclk = ~hclk;
    end
    function automatic int divisor(input logic [2:0] s);
        return s == SEL_DIV8 ? 8 : s == SEL_DIV64 ? 64 : s == SEL_DIV256 ? 256 : 1024;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rdy;
        int k = 0;
        do @(posedge hclk); while (hready !== 1'b1 && ++k < 20);
        if (k == 20) begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask
    // Records first tick of both timers, plus tick and pin edge counts of one timer.
    task automatic watch(input int i, input int cy, input logic [2:0] m);
        logic p = pin[i];
        ft = '{0, 0};
        st = 0;
        nt = 0;
        ne = 0;
        for (int c = 1; c <= cy; c++) begin
            @(posedge hclk);
            #1;
            for (int j = 0; j < 2; j++) if (ft[j] == 0 && timer_tick[j] === 1'b1) ft[j] = c;
            if (timer_tick[i] === 1'b1 && nt++ == 1) st = c;
            ne += (m == SEL_EXT_RISE) ? pin[i] & ~p : p & ~pin[i];
            p = pin[i];
        end
    endtask
    initial begin
        logic [31:0] r, wd;
        int a, b;
        logic [2:0] m;
        void'($urandom(90));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 5; k++) begin
            if (k != 3) begin
                bus(1'b0, 32'(4 * k), 32'h0, r);
                chk("reset value", 32'h0, r);
            end
        end
        $display("test reset done");
        wd = {24'h0, 7'($urandom), 1'b1};
        bus(1'b1, ADDR_TIMER1_SELECT, 32'(SEL_DIV8), r);
        bus(1'b1, ADDR_TIMER0_SELECT, 32'(SEL_DIV64), r);
        repeat ($urandom_range(1, 90)) @(posedge hclk);
        bus(1'b1, ADDR_SPECIAL_IO, wd, r);
        watch(0, 70, SEL_STOP);
        chk("slow tap after restart", 32'h40, 32'(ft[0]));
        chk("fast tap after restart", 32'h8, 32'(ft[1]));
        bus(1'b0, ADDR_SPECIAL_IO, 32'h0, r);
        chk("control readback", wd & 32'h0000_00FE, r);
        $display("test restart done");
        for (int d = 0; d < 4; d++) begin
            m = SEL_DIV8 + 3'(d);
            repeat ($urandom_range(1, 300)) @(posedge hclk);
            bus(1'b1, ADDR_TIMER0_SELECT, 32'(m), r);
            watch(0, 2 * divisor(m) + 2, m);
            chk("first tick in range", 32'h1, 32'(ft[0] >= 1 && ft[0] <= divisor(m) + 1));
            chk("tap period", 32'(divisor(m)), 32'(st - ft[0]));
        end
        $display("test taps done");
        bus(1'b1, ADDR_TIMER0_SELECT, 32'(SEL_CLK), r);
        watch(0, 2, m);
        watch(0, 8, m);
        chk("full rate ticks", 32'h8, 32'(nt));
        bus(1'b1, ADDR_TIMER0_SELECT, 32'(SEL_STOP), r);
        watch(0, 2, m);
        watch(0, 20, m);
        chk("stopped ticks", 32'h0, 32'(nt));
        $display("test rate done");
        for (int k = 0; k < 4; k++) begin
            m = k[0] ? SEL_EXT_RISE : SEL_EXT_FALL;
            bus(1'b1, k[1] ? ADDR_TIMER1_SELECT : ADDR_TIMER0_SELECT, 32'(m), r);
            half <= 4'($urandom_range(2, 5));
            run[k[1]] <= 1'b1;
            watch(k[1], 200, m);
            a = ne;
            b = nt;
            run[k[1]] <= 1'b0;
            watch(k[1], 10, m);
            chk("pin edges to ticks", 32'(a + ne), 32'(b + nt));
        end
        $display("test pin done");
        end_sim();
    end
endmodule
bind timer_prescaler_ext_clock_sync tick_gen_monitor #(.TIMERS(TIMERS)) mon (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
    .ext_count_pin(ext_count_pin), .timer_tick(timer_tick));

/* bench/tick_gen_monitor.sv */
// Assertion checker for the tick prescaler and count pin front end.
// Assumes a bind to the top module, a clock enable held high and zero wait states.
module tick_gen_monitor
    import tick_gen_pkg::*;
#(
    parameter int unsigned TIMERS = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic [TIMERS-1:0] ext_count_pin,
    input wire logic [TIMERS-1:0] timer_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [31:0] ad_r;
    logic act_r, wr_r;
    logic [2:0] s0_r;
    wire logic tk = timer_tick[0];
    wire logic pn = ext_count_pin[0];
    // Shadow of the timer 0 select, so each check knows the mode it is judging.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_r <= 1'b0;
            wr_r <= 1'b0;
            ad_r <= 32'h0000_0000;
            s0_r <= SEL_RESET;
        end else begin
            if (act_r && wr_r && ad_r == ADDR_TIMER0_SELECT) s0_r <= hwdata[2:0];
            act_r <= hsel && htrans[1];
            wr_r <= hwrite;
            ad_r <= haddr;
        end
    end
    property p_stop; s0_r == SEL_STOP && $past(s0_r) == SEL_STOP |-> !tk; endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");
    property p_full; s0_r == SEL_CLK && $past(s0_r) == SEL_CLK |-> tk; endproperty
    a_full: assert property (p_full) else $error("full rate tick missing");
    property p_rise; s0_r == SEL_EXT_RISE && $rose(pn) |-> ##[2:4] tk; endproperty
    a_rise: assert property (p_rise) else $error("rising pin edge lost");
    property p_fall; s0_r == SEL_EXT_FALL && $fell(pn) |-> ##[2:4] tk; endproperty
    a_fall: assert property (p_fall) else $error("falling pin edge lost");
    property p_single; s0_r[2:1] == 2'h3 && tk |=> !tk; endproperty
    a_single: assert property (p_single) else $error("pin tick too long");
    property p_lat; tk && s0_r == SEL_EXT_RISE && $past(s0_r, 4) == SEL_EXT_RISE |-> $past(pn, 3) && !$past(pn, 4); endproperty
    a_lat: assert property (p_lat) else $error("pin tick latency wrong");
    property p_div8; tk && s0_r == SEL_DIV8 && $past(s0_r, 9) == SEL_DIV8 |-> $past(tk, 8) && !$past(tk, 4); endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 period wrong");
    property p_rd0; act_r && !wr_r && ad_r == ADDR_SPECIAL_IO |-> hrdata[0] == 1'b0; endproperty
    a_rd0: assert property (p_rd0) else $error("restart bit read as one");
endmodule

/* logic/tick_gen_pkg.sv */
// Constants for the shared timer prescaler and external count front end.
// Assumes a single 20 MHz clock and an AHB-Lite register bus with 32-bit data.
package tick_gen_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PRESC_WIDTH = 10;
    localparam logic [9:0] PRESC_RESET = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
    localparam logic [2:0] SEL_STOP = 3'h0;
    localparam logic [2:0] SEL_CLK = 3'h1;
    localparam logic [2:0] SEL_DIV8 = 3'h2;
    localparam logic [2:0] SEL_DIV64 = 3'h3;
    localparam logic [2:0] SEL_DIV256 = 3'h4;
    localparam logic [2:0] SEL_DIV1024 = 3'h5;
    localparam logic [2:0] SEL_EXT_FALL = 3'h6;
    localparam logic [2:0] SEL_EXT_RISE = 3'h7;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [31:0] ADDR_SPECIAL_IO = 32'h0000_0000;
    localparam logic [31:0] ADDR_TIMER0_SELECT = 32'h0000_0004;
    localparam logic [31:0] ADDR_TIMER1_SELECT = 32'h0000_0008;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;
    localparam logic [7:0] SPECIAL_IO_RESET = 8'h00;
    localparam int unsigned RESTART_BIT = 0;
    localparam int unsigned SEL_MSB = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

/* logic/timer_prescaler_ext_clock_sync.sv */
// Shared prescaler and external count pin front end for two timers, with AHB-Lite registers.
// Assumes hclk is the system I/O clock; the count pins are asynchronous to it.
// Assumes word-sized transfers only; hsize is not checked.
// Notes on behaviour
// [R01] Select value 1 gives one timer tick every system clock cycle.
// [R02] Four prescaled sources divide the clock by 8, 64, 256 and 1024.
// [R03] One free-running prescaler serves both timers, each with its own select.
// [R04] First prescaled tick arrives 1 to N+1 cycles after enabling.
// [R05] A prescaler restart realigns the period for both timers.
// [R06] Each count pin is sampled every cycle, then edge detected.
// [R07] Sampling stages capture on the rising clock edge.
// [R08] One tick per edge: rising for select 7, falling for select 6.
// [R09] Pin edge to counter update takes 2.5 to 3.5 clock cycles; the flop stages here take 2 to 3 cycles.
// [R10] Outside logic switches external mode only while the pin is steady.
// [R11] External source keeps each half period above one clock cycle.
// [R12] External ticks bypass the prescaler entirely.
// [R13] Writing one to bit 0 restarts the prescaler; reads return zero.
// [R14] Select encoding: stop, clock, four divisors, falling pin, rising pin.
// [R15] Pin transitions count even when the pin is used as an output.
// [R16] Prescaler is a 10-bit counter; taps strobe when their low bits wrap.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
module timer_prescaler_ext_clock_sync
    import tick_gen_pkg::*;
#(
    parameter int unsigned TIMERS = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [TIMERS-1:0] ext_count_pin,
    output logic [TIMERS-1:0] timer_tick
);

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_t;

    bus_state_t bus_state_r;
    logic [PRESC_WIDTH-1:0] presc_r;
    logic [2:0] sel_r [TIMERS];
    logic [7:0] special_io_r;
    logic [TIMERS-1:0] pin_meta_r;
    logic [TIMERS-1:0] pin_sync_r;
    logic [TIMERS-1:0] pin_prev_r;
    logic [TIMERS-1:0] tick_r;
    logic [31:0] addr_r;
    logic write_r;
    logic [31:0] hrdata_r;

    // Each tap strobes when the counter's low bits are all ones, so the tap wraps next cycle.
    function automatic logic tap_hit(input logic [PRESC_WIDTH-1:0] cnt, input logic [PRESC_WIDTH-1:0] mask);
        tap_hit = (cnt & mask) == mask;
    endfunction

    function automatic logic tick_of(
        input logic [2:0] sel,
        input logic [3:0] taps,
        input logic rise,
        input logic fall
    );
        logic t;
        t = 1'b0;
        case (sel)
            SEL_CLK: t = 1'b1; // R01
            SEL_DIV8: t = taps[0]; // R02
            SEL_DIV64: t = taps[1];
            SEL_DIV256: t = taps[2];
            SEL_DIV1024: t = taps[3];
            SEL_EXT_FALL: t = fall; // R08 R12
            SEL_EXT_RISE: t = rise; // R08 R12
            default: t = 1'b0; // R14
        endcase
        tick_of = t;
    endfunction

    // Bit positions of the one-hot register decode.
    localparam int unsigned HIT_SPECIAL = 0;
    localparam int unsigned HIT_SEL0 = 1;
    localparam int unsigned HIT_SEL1 = 2;
    localparam int unsigned HIT_STATUS = 3;

    // The same decode serves the address phase (reads) and the data phase (writes).
    function automatic logic [3:0] reg_hit(input logic [31:0] a);
        logic [3:0] h;
        h = 4'h0;
        if (a == ADDR_SPECIAL_IO) begin
            h[HIT_SPECIAL] = 1'b1;
        end else if (a == ADDR_TIMER0_SELECT) begin
            h[HIT_SEL0] = 1'b1;
        end else if (a == ADDR_TIMER1_SELECT) begin
            h[HIT_SEL1] = 1'b1;
        end else if (a == ADDR_STATUS) begin
            h[HIT_STATUS] = 1'b1;
        end else begin
            h = 4'h0;
        end
        reg_hit = h;
    endfunction

    // Unmapped addresses read as zero; narrow fields sit in the low bits.
    function automatic logic [31:0] read_word(
        input logic [3:0] hit,
        input logic [7:0] special,
        input logic [2:0] sel0,
        input logic [2:0] sel1,
        input logic [PRESC_WIDTH-1:0] cnt
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hit[HIT_SPECIAL]) begin
            w = {24'h00_0000, special};
        end else if (hit[HIT_SEL0]) begin
            w = {29'h0000_0000, sel0};
        end else if (hit[HIT_SEL1]) begin
            w = {29'h0000_0000, sel1};
        end else if (hit[HIT_STATUS]) begin
            w = {{(32 - PRESC_WIDTH){1'b0}}, cnt};
        end else begin
            w = 32'h0000_0000;
        end
        read_word = w;
    endfunction

    wire logic take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire logic [3:0] addr_hit = reg_hit(haddr);
    wire logic [3:0] data_hit = reg_hit(addr_r);
    wire logic in_data = (bus_state_r == BUS_DATA);
    wire logic wr_data = in_data && write_r;

    wire logic wr_special = wr_data && data_hit[HIT_SPECIAL];
    wire logic wr_sel0 = wr_data && data_hit[HIT_SEL0];
    wire logic wr_sel1 = wr_data && data_hit[HIT_SEL1];
    wire logic restart = wr_special && hwdata[RESTART_BIT]; // R13 R05

    // Tap strobes last one cycle, once per wrap of the tap's low bits.
    wire logic tap8 = tap_hit(presc_r, MASK_DIV8);
    wire logic tap64 = tap_hit(presc_r, MASK_DIV64);
    wire logic tap256 = tap_hit(presc_r, MASK_DIV256);
    wire logic tap1024 = tap_hit(presc_r, MASK_DIV1024);
    wire logic [3:0] taps = {tap1024, tap256, tap64, tap8}; // R16

    // Next values of the tick, prescaler, select, special and bus registers, each worked out in one place.
    logic [TIMERS-1:0] rise;
    logic [TIMERS-1:0] fall;
    logic [TIMERS-1:0] tick_nxt;
    logic [PRESC_WIDTH-1:0] presc_nxt;
    logic [2:0] sel_nxt [TIMERS];
    logic [7:0] special_nxt;
    bus_state_t bus_state_nxt;
    logic [31:0] addr_nxt;
    logic write_nxt;

    // Edges are judged on the second sampling stage, never on the first.
    always_comb begin
        rise = '0;
        fall = '0;
        for (int i = 0; i < TIMERS; i++) begin
            rise[i] = pin_sync_r[i] && !pin_prev_r[i]; // R08
            fall[i] = !pin_sync_r[i] && pin_prev_r[i]; // R08
        end
    end

    // External ticks come straight from the edge detector, never through a tap.
    always_comb begin
        tick_nxt = '0;
        for (int i = 0; i < TIMERS; i++) begin
            tick_nxt[i] = tick_of(sel_r[i], taps, rise[i], fall[i]); // R03 R04
        end
    end

    // Restart wins over counting when both fall in one cycle.
    always_comb begin
        presc_nxt = presc_r + 10'h001; // R03 R16
        if (restart) begin
            presc_nxt = PRESC_RESET; // R05 R13
        end
    end

    // Reads use these values, so a read right behind a write sees the new value.
    always_comb begin
        for (int i = 0; i < TIMERS; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        special_nxt = special_io_r;
        if (wr_sel0) begin
            sel_nxt[0] = hwdata[SEL_MSB:0]; // R03 R14
        end else if (wr_sel1) begin
            sel_nxt[TIMERS-1] = hwdata[SEL_MSB:0]; // R03 R14
        end else if (wr_special) begin
            special_nxt = hwdata[7:0] & ~(8'h01 << RESTART_BIT); // R13
        end
    end

    // The restart bit never holds, so it always reads as zero.
    wire logic [7:0] special_rd = special_nxt & ~(8'h01 << RESTART_BIT); // R13
    wire logic [31:0] hrdata_nxt = read_word(addr_hit, special_rd, sel_nxt[0], sel_nxt[TIMERS-1], presc_nxt);

    // Back-to-back transfers keep the machine in the data state.
    always_comb begin
        bus_state_nxt = bus_state_r;
        addr_nxt = addr_r;
        write_nxt = write_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (take) begin
                    bus_state_nxt = BUS_DATA;
                    addr_nxt = haddr;
                    write_nxt = hwrite;
                end
            end
            BUS_DATA: begin
                if (take) begin
                    addr_nxt = haddr;
                    write_nxt = hwrite;
                end else begin
                    bus_state_nxt = BUS_IDLE;
                    write_nxt = 1'b0;
                end
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // The prescaler never looks at either select; it runs whatever the timers do.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_r <= PRESC_RESET;
        end else if (clk_en) begin
            presc_r <= presc_nxt; // R03 R16
        end
    end

    // The first stage is a flop, not a high-transparent latch: same one cycle of
    // uncertainty, but it keeps the design latch-free for timing analysis.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
        end else if (clk_en) begin
            pin_meta_r <= ext_count_pin; // R06 R07 R15
        end
    end

    // Only the second stage reads the first, as the pins are asynchronous to hclk.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync_r <= '0;
        end else if (clk_en) begin
            pin_sync_r <= pin_meta_r; // R07
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev_r <= '0;
        end else if (clk_en) begin
            pin_prev_r <= pin_sync_r; // R06
        end
    end

    // The registered tick keeps the output a flop; it is the last cycle of the pin latency.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_r <= '0;
        end else if (clk_en) begin
            tick_r <= tick_nxt; // R09
        end
    end

    // Timer 1's select sits in the last slot of the array.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < TIMERS; i++) begin
                sel_r[i] <= SEL_RESET;
            end
        end else if (clk_en) begin
            for (int i = 0; i < TIMERS; i++) begin
                sel_r[i] <= sel_nxt[i]; // R03 R14
            end
        end
    end

    // Other fields of the special register are plain storage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            special_io_r <= SPECIAL_IO_RESET;
        end else if (clk_en) begin
            special_io_r <= special_nxt; // R13
        end
    end

    // A frozen clock enable freezes the bus as well.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_r <= BUS_IDLE;
            addr_r <= 32'h0000_0000;
            write_r <= 1'b0;
        end else if (clk_en) begin
            bus_state_r <= bus_state_nxt;
            addr_r <= addr_nxt;
            write_r <= write_nxt;
        end
    end

    // Read data is registered at the address phase so hrdata is a flop output.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (clk_en && take && !hwrite) begin
            hrdata_r <= hrdata_nxt;
        end
    end

    // Every transfer completes at once with an OKAY answer, so there is no wait state logic.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign timer_tick = tick_r;

endmodule
